/* File: hw/ldf_framer.sv */
// d-channel link framer: flags, zero insertion/deletion, aborts, idle fill,
// address recognition and the pseudo-random counter
// assumes line strobes/bits come from another domain; control bits are on i_clk
`timescale 1ns/1ns
`default_nettype none
module ldf_framer (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_rx_bit,
  input wire logic i_rx_strobe,
  input wire logic i_tx_strobe,
  output logic o_tx_bit,
  input wire logic [7:0] i_mode_reg_one,
  input wire logic [7:0] i_mode_reg_three,
  input wire logic [7:0] i_mode_reg_four,
  input wire logic [7:0] i_error_mask_reg,
  input wire logic [7:0] i_init_reg,
  input wire logic i_match_wr,
  input wire logic i_match_second,
  input wire logic [1:0] i_match_idx,
  input wire logic [7:0] i_match_data,
  input wire logic [7:0] i_tx_byte,
  input wire logic i_tx_valid,
  input wire logic i_tx_fcs,
  input wire logic i_tx_last,
  output logic o_tx_ready,
  output logic [7:0] o_rx_byte,
  output logic o_rx_valid,
  output logic o_rx_in_progress,
  output logic o_end_of_packet,
  output logic o_addr_event,
  output logic [1:0] o_addr_len,
  input wire logic i_last_byte_read,
  input wire logic i_error_read,
  output logic o_rx_abort_err,
  output logic o_err_irq,
  input wire logic i_status_read,
  output logic o_tx_abort_status,
  input wire logic i_rng_rd_lo,
  input wire logic i_rng_rd_hi,
  input wire logic i_rng_wr_lo,
  input wire logic i_rng_wr_hi,
  input wire logic [7:0] i_rng_wdata,
  output logic [15:0] o_rng_value,
  output logic o_rng_running
);
  // line input synchronisers: stage a feeds stage b only, c is for edges
  logic [2:0] sync_a_ff, sync_b_ff;
  logic rx_stb_c_ff, tx_stb_c_ff;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync_a_ff <= 3'h0;
      sync_b_ff <= 3'h0;
      rx_stb_c_ff <= 1'b0;
      tx_stb_c_ff <= 1'b0;
    end else begin
      sync_a_ff <= {i_tx_strobe, i_rx_strobe, i_rx_bit};
      sync_b_ff <= sync_a_ff;
      rx_stb_c_ff <= sync_b_ff[1];
      tx_stb_c_ff <= sync_b_ff[2];
    end
  end
  wire logic rx_bit = sync_b_ff[0];
  wire logic rx_tick = sync_b_ff[1] & ~rx_stb_c_ff;
  wire logic tx_tick = sync_b_ff[2] & ~tx_stb_c_ff;

  // ---------------- receive ----------------
  ldf_pkg::ldf_rx_state_t rx_state_ff;
  logic [2:0] rx_ones_ff, rx_cnt_ff;
  logic [7:0] rx_sh_ff, first_ff;
  logic rx_have_first_ff, abort_pend_ff, err_abort_ff;
  logic [7:0] first_byte_match_reg_ff [4];
  logic [7:0] second_byte_match_reg_ff [4];
  logic [3:0] pair_hit;

  wire logic flag_evt = rx_tick & ~rx_bit & (rx_ones_ff == ldf_pkg::FLAG_ONES);
  wire logic seven_evt = rx_tick & rx_bit & (rx_ones_ff == ldf_pkg::FLAG_ONES);
  wire logic del_evt = rx_tick & ~rx_bit & (rx_ones_ff == ldf_pkg::STUFF_ONES);
  wire logic data_evt = rx_tick & ~flag_evt & ~seven_evt & ~del_evt;
  wire logic byte_done = data_evt & (rx_cnt_ff == ldf_pkg::LAST_BIT);
  wire logic [7:0] byte_in = {rx_bit, rx_sh_ff[7:1]};
  wire logic force_abort = i_init_reg[ldf_pkg::INIT_RX_ABORT];
  wire logic in_frame = rx_state_ff != ldf_pkg::RX_HUNT;
  wire logic abort_evt = (seven_evt | force_abort) & in_frame;
  wire logic recog_off = i_mode_reg_one[7:4] == 4'h0;
  wire logic accept = recog_off | (|pair_hit);
  wire logic addr_done = byte_done & (rx_state_ff == ldf_pkg::RX_ADDR) & rx_have_first_ff;

  // run of ones on the raw line, saturating at six
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_ones_ff <= 3'h0;
    end else if (rx_tick) begin
      if (!rx_bit) begin
        rx_ones_ff <= 3'h0;
      end else if (rx_ones_ff != ldf_pkg::FLAG_ONES) begin
        rx_ones_ff <= rx_ones_ff + 3'h1;
      end
    end
  end

  // bit assembly lsb first; stuffed zeros skipped, flags realign
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_sh_ff <= 8'h00;
      rx_cnt_ff <= ldf_pkg::FIRST_BIT;
    end else if (flag_evt) begin
      rx_cnt_ff <= ldf_pkg::FIRST_BIT;
    end else if (data_evt) begin
      rx_sh_ff <= byte_in;
      rx_cnt_ff <= rx_cnt_ff + 3'h1;
    end
  end

  // match registers, one pair per entry; fourth pair resets to broadcast
  for (genvar g = 0; g < 4; g++) begin : g_pair
    localparam logic [7:0] F_RST = (g == 3) ? ldf_pkg::FIRST_MATCH_FOUR_RST :
                                              ldf_pkg::MATCH_OTHER_RST;
    localparam logic [7:0] S_RST = (g == 3) ? ldf_pkg::SECOND_MATCH_FOUR_RST :
                                              ldf_pkg::MATCH_OTHER_RST;
    wire logic [7:0] f_mask = i_mode_reg_four[ldf_pkg::M4_CR_COMPARE] ?
                              ldf_pkg::FULL_MASK : ldf_pkg::CR_IGNORE_MASK;
    wire logic f_hit = ((first_ff ^ first_byte_match_reg_ff[g]) & f_mask) == 8'h00;
    wire logic s_hit = byte_in == second_byte_match_reg_ff[g];
    wire logic en = i_mode_reg_one[ldf_pkg::M1_PAIR_EN_LO + g];
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        first_byte_match_reg_ff[g] <= F_RST;
        second_byte_match_reg_ff[g] <= S_RST;
      end else if (i_match_wr && i_match_idx == 2'(g)) begin
        if (i_match_second) begin
          second_byte_match_reg_ff[g] <= i_match_data;
        end else begin
          first_byte_match_reg_ff[g] <= i_match_data;
        end
      end
    end
    // recognition type from mode four bits 5 and 7
    always_comb begin
      if (!i_mode_reg_four[ldf_pkg::M4_BYTE_ONLY]) begin
        pair_hit[g] = en & f_hit & s_hit;
      end else if (i_mode_reg_four[ldf_pkg::M4_SECOND_ONLY]) begin
        pair_hit[g] = en & s_hit;
      end else begin
        pair_hit[g] = en & f_hit;
      end
    end
  end

  // receive state: hunt, address, data
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_state_ff <= ldf_pkg::RX_HUNT;
      rx_have_first_ff <= 1'b0;
      first_ff <= 8'h00;
    end else if (abort_evt || (force_abort && !in_frame)) begin
      rx_state_ff <= ldf_pkg::RX_HUNT;
      rx_have_first_ff <= 1'b0;
    end else begin
      unique case (rx_state_ff)
        ldf_pkg::RX_HUNT: begin
          if (flag_evt) begin
            rx_state_ff <= ldf_pkg::RX_ADDR;
          end
        end
        ldf_pkg::RX_ADDR: begin
          if (flag_evt) begin
            rx_have_first_ff <= 1'b0;
          end else if (byte_done && !rx_have_first_ff) begin
            first_ff <= byte_in;
            rx_have_first_ff <= 1'b1;
          end else if (addr_done) begin
            rx_state_ff <= accept ? ldf_pkg::RX_DATA : ldf_pkg::RX_HUNT;
            rx_have_first_ff <= 1'b0;
          end
        end
        ldf_pkg::RX_DATA: begin
          if (flag_evt) begin
            rx_state_ff <= ldf_pkg::RX_ADDR;
          end
        end
      endcase
    end
  end

  // packet status and received bytes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rx_in_progress <= 1'b0;
      o_end_of_packet <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_byte <= 8'h00;
      o_addr_event <= 1'b0;
      o_addr_len <= ldf_pkg::ALEN_NONE;
    end else begin
      o_end_of_packet <= o_rx_in_progress && (abort_evt || flag_evt);
      o_rx_valid <= byte_done && rx_state_ff == ldf_pkg::RX_DATA && !abort_evt;
      o_addr_event <= addr_done && !abort_evt && accept &&
                      i_mode_reg_three[ldf_pkg::M3_ADDR_IRQ_EN];
      if (byte_done) begin
        o_rx_byte <= byte_in;
      end
      if (addr_done && !abort_evt) begin
        o_addr_len <= first_ff[0] ? ldf_pkg::ALEN_ONE :
                      (byte_in[0] ? ldf_pkg::ALEN_TWO : ldf_pkg::ALEN_LONG);
      end
      // in-progress clears on an abort, a rejected address or a closing flag; end of packet also pulses on an abort
      if (abort_evt || (addr_done && !accept)) begin
        o_rx_in_progress <= 1'b0;
      end else if (flag_evt && rx_state_ff != ldf_pkg::RX_HUNT) begin
        o_rx_in_progress <= 1'b0;
      end else if (byte_done && rx_state_ff == ldf_pkg::RX_ADDR) begin
        o_rx_in_progress <= 1'b1;
      end
    end
  end

  // abort error: pending until the packet's last byte is read; set wins
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      abort_pend_ff <= 1'b0;
      err_abort_ff <= 1'b0;
      o_err_irq <= 1'b0;
    end else begin
      if (abort_evt && o_rx_in_progress) begin
        abort_pend_ff <= 1'b1;
      end else if (i_last_byte_read) begin
        abort_pend_ff <= 1'b0;
      end
      if (i_last_byte_read && abort_pend_ff) begin
        err_abort_ff <= 1'b1;
      end else if (i_error_read) begin
        err_abort_ff <= 1'b0;
      end
      o_err_irq <= (err_abort_ff || (i_last_byte_read && abort_pend_ff)) &&
                   i_error_mask_reg[ldf_pkg::ERR_ABORT_BIT];
    end
  end
  assign o_rx_abort_err = err_abort_ff;

  // ---------------- transmit ----------------
  ldf_pkg::ldf_tx_state_t tx_state_ff;
  logic [2:0] tx_fcnt_ff, tx_bcnt_ff, tx_ones_ff, tx_abcnt_ff;
  logic [7:0] tx_sh_ff;
  logic tx_fcs_ff, tx_last_ff;
  wire logic tx_abort = i_init_reg[ldf_pkg::INIT_TX_ABORT];
  wire logic flag_idle = i_mode_reg_four[ldf_pkg::M4_FLAG_IDLE];
  wire logic flag_bit = (tx_fcnt_ff != ldf_pkg::FIRST_BIT) && (tx_fcnt_ff != ldf_pkg::LAST_BIT);
  wire logic tx_stuff = tx_ones_ff == ldf_pkg::STUFF_ONES;
  wire logic data_bit = tx_fcs_ff ? tx_sh_ff[ldf_pkg::LAST_BIT - tx_bcnt_ff] :
                                    tx_sh_ff[tx_bcnt_ff];
  wire logic tx_start = !flag_idle || tx_fcnt_ff == ldf_pkg::FIRST_BIT;

  // transmit sequencer, advanced once per line bit request
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_state_ff <= ldf_pkg::TX_IDLE;
      tx_fcnt_ff <= ldf_pkg::FIRST_BIT;
      tx_bcnt_ff <= ldf_pkg::FIRST_BIT;
      tx_ones_ff <= 3'h0;
      tx_abcnt_ff <= ldf_pkg::FIRST_BIT;
      tx_sh_ff <= 8'h00;
      tx_fcs_ff <= 1'b0;
      tx_last_ff <= 1'b0;
      o_tx_bit <= 1'b1;
      o_tx_ready <= 1'b0;
      o_tx_abort_status <= 1'b0;
    end else begin
      o_tx_ready <= 1'b0;
      if (tx_tick && tx_abort && tx_abcnt_ff == ldf_pkg::LAST_BIT) begin
        o_tx_abort_status <= 1'b1;
      end else if (i_status_read) begin
        o_tx_abort_status <= 1'b0;
      end
      if (!tx_abort) begin
        tx_abcnt_ff <= ldf_pkg::FIRST_BIT;
      end
      if (tx_tick && tx_abort) begin
        // seven ones then a zero, repeated; frame dropped
        o_tx_bit <= tx_abcnt_ff != ldf_pkg::LAST_BIT;
        tx_abcnt_ff <= tx_abcnt_ff + 3'h1;
        tx_state_ff <= ldf_pkg::TX_IDLE;
        tx_fcnt_ff <= ldf_pkg::FIRST_BIT;
      end else if (tx_tick) begin
        unique case (tx_state_ff)
          ldf_pkg::TX_IDLE: begin
            if (i_tx_valid && tx_start) begin
              tx_state_ff <= ldf_pkg::TX_OPEN;
              o_tx_bit <= 1'b0;
              tx_fcnt_ff <= 3'h1;
            end else begin
              o_tx_bit <= flag_idle ? flag_bit : 1'b1;
              tx_fcnt_ff <= flag_idle ? tx_fcnt_ff + 3'h1 : ldf_pkg::FIRST_BIT;
            end
          end
          ldf_pkg::TX_OPEN: begin
            o_tx_bit <= flag_bit;
            tx_fcnt_ff <= tx_fcnt_ff + 3'h1;
            if (tx_fcnt_ff == ldf_pkg::LAST_BIT) begin
              tx_ones_ff <= 3'h0;
              tx_bcnt_ff <= ldf_pkg::FIRST_BIT;
              if (i_tx_valid) begin
                tx_state_ff <= ldf_pkg::TX_DATA;
                tx_sh_ff <= i_tx_byte;
                tx_fcs_ff <= i_tx_fcs;
                tx_last_ff <= i_tx_last;
                o_tx_ready <= 1'b1;
              end else begin
                tx_state_ff <= ldf_pkg::TX_IDLE;
              end
            end
          end
          ldf_pkg::TX_DATA: begin
            if (tx_stuff) begin
              o_tx_bit <= 1'b0;
              tx_ones_ff <= 3'h0;
            end else begin
              o_tx_bit <= data_bit;
              tx_ones_ff <= data_bit ? tx_ones_ff + 3'h1 : 3'h0;
              tx_bcnt_ff <= tx_bcnt_ff + 3'h1;
              if (tx_bcnt_ff == ldf_pkg::LAST_BIT) begin
                if (!tx_last_ff && i_tx_valid) begin
                  tx_sh_ff <= i_tx_byte;
                  tx_fcs_ff <= i_tx_fcs;
                  tx_last_ff <= i_tx_last;
                  o_tx_ready <= 1'b1;
                end else begin
                  tx_state_ff <= ldf_pkg::TX_CLOSE;
                  tx_fcnt_ff <= ldf_pkg::FIRST_BIT;
                end
              end
            end
          end
          ldf_pkg::TX_CLOSE: begin
            if (tx_stuff) begin
              o_tx_bit <= 1'b0;
              tx_ones_ff <= 3'h0;
            end else begin
              o_tx_bit <= flag_bit;
              tx_fcnt_ff <= tx_fcnt_ff + 3'h1;
              if (tx_fcnt_ff == ldf_pkg::LAST_BIT) begin
                tx_state_ff <= ldf_pkg::TX_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  ldf_random_counter u_rng (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_rd_lo(i_rng_rd_lo),
    .i_rd_hi(i_rng_rd_hi),
    .i_wr_lo(i_rng_wr_lo),
    .i_wr_hi(i_rng_wr_hi),
    .i_wdata(i_rng_wdata),
    .o_value(o_rng_value),
    .o_running(o_rng_running)
  );

  a_abort_eop: assert property (@(posedge i_clk) disable iff (i_rst)
    seven_evt && o_rx_in_progress |=> o_end_of_packet && !o_rx_in_progress)
    else $error("seven ones did not end the packet");
  a_abort_err_set: assert property (@(posedge i_clk) disable iff (i_rst)
    i_last_byte_read && abort_pend_ff |=> o_rx_abort_err ##1
    (o_err_irq == i_error_mask_reg[0] || $past(i_error_read)))
    else $error("abort error not raised on last byte read");
  a_force_abort: assert property (@(posedge i_clk) disable iff (i_rst)
    force_abort |=> rx_state_ff == ldf_pkg::RX_HUNT && !o_rx_in_progress)
    else $error("forced receive abort ignored");
  a_tx_abort_seq: assert property (@(posedge i_clk) disable iff (i_rst)
    tx_tick && tx_abort && tx_abcnt_ff == ldf_pkg::LAST_BIT |=>
    !o_tx_bit && o_tx_abort_status)
    else $error("abort sequence did not end in zero with status");
  a_stuff_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    tx_tick && !tx_abort && tx_stuff && tx_state_ff == ldf_pkg::TX_DATA |=>
    !o_tx_bit && tx_ones_ff == 3'h0)
    else $error("no zero after five ones");
  a_mark_idle: assert property (@(posedge i_clk) disable iff (i_rst)
    tx_tick && !tx_abort && tx_state_ff == ldf_pkg::TX_IDLE && !flag_idle && !i_tx_valid
    |=> o_tx_bit)
    else $error("mark idle fill not ones");
  a_destuff: assert property (@(posedge i_clk) disable iff (i_rst)
    del_evt |=> $stable(rx_cnt_ff) && $stable(rx_sh_ff))
    else $error("stuffed zero was kept");
  a_open_addr: assert property (@(posedge i_clk) disable iff (i_rst)
    addr_done && !abort_evt && recog_off && i_mode_reg_three[0] |=>
    o_addr_event && rx_state_ff == ldf_pkg::RX_DATA)
    else $error("all addresses not accepted");
  a_reject_addr: assert property (@(posedge i_clk) disable iff (i_rst)
    addr_done && !abort_evt && !accept |=>
    rx_state_ff == ldf_pkg::RX_HUNT && !o_addr_event && !o_rx_in_progress)
    else $error("unmatched packet not discarded");
endmodule // ldf_framer
`default_nettype wire

/* File: hw/ldf_pkg.sv */
// package for the d-channel framer: field positions, reset values, counts, states
// assumes line inputs are synchronised to i_clk in the framer and plain-port control bits
package ldf_pkg;
  // match register reset values (fourth pair is the broadcast address)
  localparam logic [7:0] FIRST_MATCH_FOUR_RST = 8'hfe;
  localparam logic [7:0] SECOND_MATCH_FOUR_RST = 8'hff;
  localparam logic [7:0] MATCH_OTHER_RST = 8'h00;
  localparam logic [7:0] CR_IGNORE_MASK = 8'hfd;
  localparam logic [7:0] FULL_MASK = 8'hff;
  // bit positions inside the mode, init and mask bytes
  localparam int M1_PAIR_EN_LO = 4;
  localparam int M3_ADDR_IRQ_EN = 0;
  localparam int M4_FLAG_IDLE = 4;
  localparam int M4_BYTE_ONLY = 5;
  localparam int M4_CR_COMPARE = 6;
  localparam int M4_SECOND_ONLY = 7;
  localparam int INIT_RX_ABORT = 6;
  localparam int INIT_TX_ABORT = 7;
  localparam int ERR_ABORT_BIT = 0;
  // counts of ones and bits
  localparam logic [2:0] STUFF_ONES = 3'h5;
  localparam logic [2:0] FLAG_ONES = 3'h6;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] FIRST_BIT = 3'h0;
  // random counter value after reset
  localparam logic [15:0] RNG_RST = 16'h0000;
  // address length classes
  localparam logic [1:0] ALEN_NONE = 2'h0;
  localparam logic [1:0] ALEN_ONE = 2'h1;
  localparam logic [1:0] ALEN_TWO = 2'h2;
  localparam logic [1:0] ALEN_LONG = 2'h3;
  typedef enum logic [2:0] {
    RX_HUNT = 3'b001,
    RX_ADDR = 3'b010,
    RX_DATA = 3'b100
  } ldf_rx_state_t;
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_OPEN = 4'b0010,
    TX_DATA = 4'b0100,
    TX_CLOSE = 4'b1000
  } ldf_tx_state_t;
endpackage

/* File: hw/ldf_random_counter.sv */
// 16-bit pseudo-random counter with byte-wise processor access
// assumes read and write strobes are one-cycle pulses on i_clk
`timescale 1ns/1ns
`default_nettype none
module ldf_random_counter (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_rd_lo,
  input wire logic i_rd_hi,
  input wire logic i_wr_lo,
  input wire logic i_wr_hi,
  input wire logic [7:0] i_wdata,
  output logic [15:0] o_value,
  output logic o_running
);
  logic [15:0] cnt_ff;
  logic run_ff;

  // run control: reset clears and starts, accesses halt, low write restarts
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      run_ff <= 1'b1;
    end else if (i_wr_lo) begin
      run_ff <= 1'b1;
    end else if (i_rd_lo || i_rd_hi || i_wr_hi) begin
      run_ff <= 1'b0;
    end
  end

  // counter value and byte loads
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_ff <= ldf_pkg::RNG_RST;
    end else if (i_wr_lo) begin
      cnt_ff <= {cnt_ff[15:8], i_wdata};
    end else if (i_wr_hi) begin
      cnt_ff <= {i_wdata, cnt_ff[7:0]};
    end else if (run_ff && !i_rd_lo && !i_rd_hi) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  assign o_value = cnt_ff;
  assign o_running = run_ff;

  a_rng_halts: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_rd_lo || i_rd_hi) && !i_wr_lo && !i_wr_hi ##1 !i_wr_lo && !i_wr_hi |=>
    $stable(o_value))
    else $error("counter moved after a read");
  a_rng_restart: assert property (@(posedge i_clk) disable iff (i_rst)
    i_wr_lo ##1 (!i_rd_lo && !i_rd_hi && !i_wr_lo && !i_wr_hi) |=>
    o_value == $past(o_value) + 16'h0001)
    else $error("counter not running after low byte write");
  a_rng_hi_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    i_wr_hi && !i_wr_lo |=> !o_running && o_value[15:8] == $past(i_wdata))
    else $error("high byte write did not load and halt");
endmodule // ldf_random_counter
`default_nettype wire

/* File: verification/ldf_line_model.sv */
// line side model: delivers rx bits on a strobe, pulls tx bits with a strobe
// assumes the framer syncs both strobes through two flops on i_clk
`timescale 1ns/1ns
`default_nettype none
module ldf_line_model (
  input wire logic i_clk,
  input wire logic i_tx_bit,
  output logic o_rx_bit,
  output logic o_rx_strobe,
  output logic o_tx_strobe
);
  // line at rest before any traffic
  initial begin
    o_rx_bit = 1'b1;
    o_rx_strobe = 1'b0;
    o_tx_strobe = 1'b0;
  end
  // one receive bit, strobe high and low 4 clk each
  task automatic send_bit(input logic b);
    @(posedge i_clk) #1;
    o_rx_bit = b;
    o_rx_strobe = 1'b1;
    repeat (4) @(posedge i_clk);
    #1 o_rx_strobe = 1'b0;
    o_rx_bit = ~b; // data no longer held after the strobe
    repeat (4) @(posedge i_clk);
    #1; // hand back off the sampling edge
  endtask
  // one transmit bit, sampled once the framer has updated the line
  task automatic get_bit(output logic b);
    @(posedge i_clk) #1;
    o_tx_strobe = 1'b1;
    repeat (6) @(posedge i_clk);
    b = i_tx_bit;
    #1 o_tx_strobe = 1'b0;
    repeat (4) @(posedge i_clk);
    #1; // hand back off the sampling edge
  endtask
endmodule // ldf_line_model
`default_nettype wire

/* File: verification/lapd_dchannel_framer_tb.sv */
// testbench for the d-channel framer: counter, transmit, receive, aborts
// assumes ldf_line_model on the line side and a 125 MHz clock
`timescale 1ns/1ns
`default_nettype none
module lapd_dchannel_framer_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rxb, rxs, txs, txb, rdy, rxv, inp, eop, aev, aerr, eirq, tab, run;
  logic [7:0] m1 = 8'h00, m3 = 8'h01, m4 = 8'h00, mask = 8'h01, init = 8'h00;
  logic [7:0] wd = 8'h00, rxd, mdat = 8'h00;
  logic lbr = 1'b0, erd = 1'b0, srd = 1'b0, sclr = 1'b0, mwr = 1'b0, msec = 1'b0;
  logic [1:0] midx = 2'h0;
  logic rlo = 1'b0, rhi = 1'b0, wlo = 1'b0, whi = 1'b0;
  logic [1:0] alen;
  logic [15:0] pseudo_random_counter;
  logic [2:0] seen = 3'h0;
  logic [24:0] seq;
  int err_total = 0;
  int n_checks = 0;
  int ones = 0;
  int tx_due = 0;
  int tx_done = 0;
  // two bytes offered: plain 0xff, then a last check byte 0x01 sent msb first
  wire logic txv = tx_done < tx_due;
  wire logic txl = tx_done == 1;
  wire logic [7:0] txd = (tx_done == 0) ? 8'hff : 8'h01;
  always #4 clk = ~clk;
  ldf_line_model ldf_line_model_i (.i_clk(clk), .i_tx_bit(txb), .o_rx_bit(rxb),
    .o_rx_strobe(rxs), .o_tx_strobe(txs));
  ldf_framer ldf_framer_i (.i_clk(clk), .i_rst(rst), .i_rx_bit(rxb), .i_rx_strobe(rxs),
    .i_tx_strobe(txs), .o_tx_bit(txb), .i_mode_reg_one(m1), .i_mode_reg_three(m3),
    .i_mode_reg_four(m4), .i_error_mask_reg(mask), .i_init_reg(init),
    .i_match_wr(mwr), .i_match_second(msec), .i_match_idx(midx), .i_match_data(mdat),
    .i_tx_byte(txd), .i_tx_valid(txv), .i_tx_fcs(txl), .i_tx_last(txl),
    .o_tx_ready(rdy), .o_rx_byte(rxd), .o_rx_valid(rxv), .o_rx_in_progress(inp),
    .o_end_of_packet(eop), .o_addr_event(aev), .o_addr_len(alen),
    .i_last_byte_read(lbr), .i_error_read(erd), .o_rx_abort_err(aerr), .o_err_irq(eirq),
    .i_status_read(srd), .o_tx_abort_status(tab), .i_rng_rd_lo(rlo), .i_rng_rd_hi(rhi),
    .i_rng_wr_lo(wlo), .i_rng_wr_hi(whi), .i_rng_wdata(wd), .o_rng_value(pseudo_random_counter),
    .o_rng_running(run));
  // sticky record of end, address and byte pulses; sclr empties it
  always @(posedge clk) seen <= (rst || sclr) ? 3'h0 : seen | {eop, aev, rxv};
  // byte taken, move the offer on
  always @(posedge clk) if (rdy) tx_done <= tx_done + 1;
  task automatic check(input logic [24:0] got, input logic [24:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge clk) #1;
    s = 1'b0;
    @(posedge clk) #1;
  endtask
  // byte lsb first, zero stuffed after five ones unless raw
  task automatic send_byte(input logic [7:0] b, input bit raw);
    for (int i = 0; i < 8; i++) begin
      ldf_line_model_i.send_bit(b[i]);
      ones = b[i] ? ones + 1 : 0;
      if (ones == 5 && !raw) begin
        ldf_line_model_i.send_bit(1'b0);
        ones = 0;
      end
    end
  endtask
  task automatic grab(input int n);
    logic b;
    seq = '0;
    for (int i = 0; i < n; i++) begin
      ldf_line_model_i.get_bit(b);
      seq = {seq[23:0], b};
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    #400000;
    err_total++;
    summarize();
  end
  initial begin
    logic b;
    repeat (6) @(posedge clk);
    #1;
    check(pseudo_random_counter, 16'h0000);
    rst = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    check({run, pseudo_random_counter != 16'h0000}, 2'b11);
    pulse(rlo);
    seq = {9'h000, pseudo_random_counter};
    repeat (5) @(posedge clk);
    #1;
    check({run, pseudo_random_counter}, {1'b0, seq[15:0]});
    wd = 8'h12;
    pulse(whi);
    check({run, pseudo_random_counter[15:8]}, {1'b0, 8'h12});
    wd = 8'h34;
    pulse(wlo);
    repeat (2) @(posedge clk);
    #1;
    check({run, pseudo_random_counter > 16'h1234}, 2'b11);
    pulse(rhi);
    check(run, 1'b0);
    $display("test counter finished");
    tx_due = 2;
    b = 1'b1;
    for (int i = 0; i < 20 && b; i++) ldf_line_model_i.get_bit(b);
    check(b, 1'b0);
    grab(25);
    check(seq, 25'h1fbee02);
    grab(8);
    check(seq[7:0], 8'hfd);
    m4 = 8'h10;
    grab(8);
    check(seq[7:0], 8'h7e);
    m4 = 8'h00;
    $display("test transmit finished");
    send_byte(8'h7e, 1);
    send_byte(8'h02, 0);
    check(inp, 1'b1);
    send_byte(8'h03, 0);
    check({alen, seen[1]}, 3'h5);
    send_byte(8'hbe, 0);
    send_byte(8'h7e, 1);
    check({rxd, seen, inp}, {8'hbe, 3'h7, 1'b0});
    $display("test receive finished");
    // pair two: first byte 04 (bit 1 ignored unless asked), second byte 03
    pulse(sclr);
    m1 = 8'h20;
    midx = 2'h1;
    mdat = 8'h04;
    pulse(mwr);
    msec = 1'b1;
    mdat = 8'h03;
    pulse(mwr);
    send_byte(8'h7e, 1);
    send_byte(8'h06, 0);
    send_byte(8'h03, 0);
    check({seen[1], inp}, 2'b11);
    send_byte(8'h7e, 1);
    pulse(sclr);
    m4 = 8'h40;
    send_byte(8'h06, 0);
    send_byte(8'h03, 0);
    check({seen[1], inp}, 2'b00);
    m1 = 8'h00;
    m4 = 8'h00;
    $display("test address match finished");
    pulse(sclr);
    send_byte(8'h7e, 1);
    send_byte(8'h02, 0);
    send_byte(8'hff, 1);
    check({seen, inp}, 4'h8);
    pulse(lbr);
    check({aerr, eirq}, 2'b11);
    pulse(erd);
    check({aerr, eirq}, 2'b00);
    send_byte(8'h7e, 1);
    send_byte(8'h02, 0);
    init = 8'h40;
    repeat (4) @(posedge clk);
    #1;
    check(inp, 1'b0);
    init = 8'h00;
    $display("test receive abort finished");
    init = 8'h80;
    grab(16);
    check({tab, seq[15:0]}, 17'h1fefe);
    pulse(srd);
    check(tab, 1'b0);
    init = 8'h00;
    $display("test transmit abort finished");
    summarize();
  end
endmodule // lapd_dchannel_framer_tb
`default_nettype wire
